// *** inc/oppp_pkg.sv ***
// constants and carriers for the external prom programmer controller
// assumes a 25 MHz ref_clk and a byte-wide prom port on the target pins
// Summary of operation
// - to enter prom mode both mode pins and standby go low, p63/p64 high.
// - ce/oe/strobe levels pick write, verify or inhibit with data hi-z.
// - only addresses from zero to the top of the part size are written.
// - data above the valid range is treated as ff and never written.
// - no page programming is used, one address per write pulse.
// - bytes are written one at a time by the high-speed byte method.
// - every unprogrammed address must read back ff after the run.
package oppp_pkg;
  localparam int CLK_MHZ = 25;
  localparam int T_SETUP_US = 2;
  localparam int SETUP_CYC = T_SETUP_US * CLK_MHZ;
  localparam int T_PW_NS = 200000;
  localparam int PW_CYC = (T_PW_NS * CLK_MHZ + 999) / 1000;
  localparam int T_OE_NS = 150;
  localparam int OE_CYC = (T_OE_NS * CLK_MHZ + 999) / 1000 + 1;
  localparam int MAX_TRIES = 25;
  localparam logic [16:0] TOP_48K = 17'h0_BFFF;
  localparam logic [16:0] TOP_32K = 17'h0_7FFF;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic standby_pin_n;
    logic port_six_pin_three;
    logic port_six_pin_four;
  } oppp_mode_t;
  typedef struct packed {
    logic chip_enable_n;
    logic output_enable_n;
    logic program_strobe_n;
  } oppp_ctl_t;
endpackage

// *** verilog/oppp_timer.sv ***
// down counter used for the programmer's setup, pulse and access waits
// assumes load and count come from logic on the same clock
`timescale 1ns/1ps
module oppp_timer #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_reg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= value;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end
  // done depends on the count alone, so a load keyed on done cannot loop back
  assign done = (cnt_reg == '0);
endmodule // oppp_timer

// *** verilog/oppp_programmer.sv ***
// external programmer that writes and verifies the target's on-chip prom
// assumes the user supplies one byte per address on a valid/ready stream;
// prom_data_bus is resolved from oe outside this module
`timescale 1ns/1ps
module oppp_programmer #(
  parameter int PW_CYCLES = oppp_pkg::PW_CYC,
  parameter logic BIG_PART = 1'b1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  output logic busy,
  output logic done,
  output logic fail,
  output oppp_pkg::oppp_mode_t mode_pins,
  output oppp_pkg::oppp_ctl_t ctl_pins,
  output logic [16:0] prom_address_bus,
  output logic [7:0] prom_data_out,
  output logic prom_data_oe,
  input wire logic [7:0] prom_data_in
);
  typedef enum {
    OPPP_IDLE, OPPP_ENTER, OPPP_FETCH, OPPP_SETUP, OPPP_PULSE,
    OPPP_HOLD, OPPP_VSET, OPPP_VREAD, OPPP_NEXT, OPPP_END
  } oppp_state_t;
  localparam int TW = 18;
  localparam logic [16:0] TOP = BIG_PART ? oppp_pkg::TOP_48K
                                         : oppp_pkg::TOP_32K;
  oppp_state_t state_reg;
  logic [7:0] s1_reg, s2_reg;
  logic [7:0] data_reg;
  logic [7:0] tries_reg;
  logic t_load;
  logic [TW-1:0] t_val;
  logic t_done;
  function automatic oppp_pkg::oppp_ctl_t sub_mode(input logic wr,
                                                   input logic rd);
    oppp_pkg::oppp_ctl_t c;
    c.chip_enable_n = !(wr || rd);
    c.output_enable_n = !rd;
    c.program_strobe_n = !wr;
    return c;
  endfunction
  oppp_timer #(.W(TW)) u_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(t_load),
    .value(t_val),
    .done(t_done)
  );
  always_comb begin
    t_load = 1'b0;
    t_val = TW'(oppp_pkg::SETUP_CYC);
    case (state_reg)
      OPPP_ENTER, OPPP_NEXT: t_load = 1'b0;
      OPPP_FETCH: begin
        t_load = byte_valid && byte_ready;
      end
      OPPP_SETUP: begin
        t_load = t_done;
        t_val = TW'(PW_CYCLES);
      end
      OPPP_PULSE: t_load = t_done;
      OPPP_HOLD: t_load = t_done;
      OPPP_VSET: begin
        t_load = t_done;
        t_val = TW'(oppp_pkg::OE_CYC);
      end
      // a retry waits out the same data setup as a first pulse
      OPPP_VREAD: t_load = t_done;
      default: t_load = (state_reg == OPPP_IDLE) && start;
    endcase
  end
  // pin inputs pass two flops before use
  always_ff @(posedge ref_clk) begin
    s1_reg <= prom_data_in;
    s2_reg <= s1_reg;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= OPPP_IDLE;
    end else begin
      case (state_reg)
        OPPP_IDLE: if (start) state_reg <= OPPP_ENTER;
        OPPP_ENTER: if (t_done) state_reg <= OPPP_FETCH;
        OPPP_FETCH: begin
          if (byte_valid && byte_ready) begin
            // blank bytes are left erased, never pulsed
            if (byte_data == oppp_pkg::BLANK_BYTE) begin
              state_reg <= OPPP_NEXT;
            end else begin
              state_reg <= OPPP_SETUP;
            end
          end
        end
        OPPP_SETUP: if (t_done) state_reg <= OPPP_PULSE;
        OPPP_PULSE: if (t_done) state_reg <= OPPP_HOLD;
        OPPP_HOLD: if (t_done) state_reg <= OPPP_VSET;
        OPPP_VSET: if (t_done) state_reg <= OPPP_VREAD;
        OPPP_VREAD: begin
          if (t_done) begin
            if (s2_reg == data_reg) begin
              state_reg <= OPPP_NEXT;
            end else if (tries_reg >= 8'(oppp_pkg::MAX_TRIES)) begin
              state_reg <= OPPP_END;
            end else begin
              state_reg <= OPPP_SETUP;
            end
          end
        end
        OPPP_NEXT: begin
          // stop at the part's top; higher addresses stay ff
          if (prom_address_bus == TOP) begin
            state_reg <= OPPP_END;
          end else begin
            state_reg <= OPPP_FETCH;
          end
        end
        OPPP_END: if (!start) state_reg <= OPPP_IDLE;
        default: state_reg <= OPPP_IDLE;
      endcase
    end
  end
  // one address per pulse, never a page
  always_ff @(posedge ref_clk) begin
    if (srst || state_reg == OPPP_IDLE) begin
      prom_address_bus <= '0;
    end else if (state_reg == OPPP_NEXT && prom_address_bus != TOP) begin
      prom_address_bus <= prom_address_bus + 17'h0_0001;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_reg <= oppp_pkg::BLANK_BYTE;
      tries_reg <= '0;
    end else if (state_reg == OPPP_FETCH && byte_valid && byte_ready) begin
      data_reg <= byte_data;
      tries_reg <= '0;
    end else if (state_reg == OPPP_SETUP && t_done) begin
      tries_reg <= tries_reg + 8'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_pins <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      ctl_pins <= sub_mode(1'b0, 1'b0);
      prom_data_oe <= 1'b0;
      prom_data_out <= oppp_pkg::BLANK_BYTE;
    end else begin
      if (state_reg == OPPP_IDLE) begin
        mode_pins <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      end else begin
        mode_pins <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
      end
      ctl_pins <= sub_mode(state_reg == OPPP_PULSE,
                           state_reg == OPPP_VREAD);
      prom_data_oe <= (state_reg == OPPP_SETUP || state_reg == OPPP_PULSE ||
                       state_reg == OPPP_HOLD);
      prom_data_out <= data_reg;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      byte_ready <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
    end else begin
      // raised from the step state so a blank address costs two cycles
      byte_ready <= (state_reg == OPPP_FETCH && !(byte_valid && byte_ready))
                    || (state_reg == OPPP_NEXT && prom_address_bus != TOP);
      busy <= (state_reg != OPPP_IDLE) && (state_reg != OPPP_END);
      if (state_reg == OPPP_IDLE) begin
        done <= 1'b0;
        fail <= 1'b0;
      end else if (state_reg == OPPP_VREAD && t_done &&
                   s2_reg != data_reg &&
                   tries_reg >= 8'(oppp_pkg::MAX_TRIES)) begin
        fail <= 1'b1;
        done <= 1'b1;
      end else if (state_reg == OPPP_NEXT && prom_address_bus == TOP) begin
        done <= 1'b1;
      end
    end
  end
  property p_wr_pulse;
    @(posedge ref_clk) disable iff (srst)
      $fell(ctl_pins.program_strobe_n) |-> prom_data_oe;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("strobe low without data driven");
  property p_no_contention;
    @(posedge ref_clk) disable iff (srst)
      !ctl_pins.output_enable_n |-> !prom_data_oe;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("oe low while data driven");
  property p_mode_entry;
    @(posedge ref_clk) disable iff (srst)
      !ctl_pins.chip_enable_n |-> (!mode_pins.mode_select_high &&
        !mode_pins.mode_select_low && !mode_pins.standby_pin_n &&
        mode_pins.port_six_pin_three && mode_pins.port_six_pin_four);
  endproperty
  a_mode_entry: assert property (p_mode_entry)
    else $error("access outside prom mode");
  property p_range;
    @(posedge ref_clk) disable iff (srst)
      prom_address_bus <= TOP;
  endproperty
  a_range: assert property (p_range)
    else $error("address beyond part top");
  property p_one_mode;
    @(posedge ref_clk) disable iff (srst)
      !(!ctl_pins.program_strobe_n && !ctl_pins.output_enable_n);
  endproperty
  a_one_mode: assert property (p_one_mode)
    else $error("write and verify together");
  property p_verify_after;
    @(posedge ref_clk) disable iff (srst)
      $rose(ctl_pins.program_strobe_n) |->
        ##[1:200] !ctl_pins.output_enable_n;
  endproperty
  a_verify_after: assert property (p_verify_after)
    else $error("no verify after write");
  property p_blank_skip;
    @(posedge ref_clk) disable iff (srst)
      (state_reg == OPPP_FETCH && byte_valid && byte_ready &&
       byte_data == oppp_pkg::BLANK_BYTE) |=> state_reg == OPPP_NEXT;
  endproperty
  a_blank_skip: assert property (p_blank_skip)
    else $error("blank byte was programmed");
  property p_addr_step;
    @(posedge ref_clk) disable iff (srst)
      $past(state_reg) != OPPP_IDLE && $changed(prom_address_bus) |->
        prom_address_bus == $past(prom_address_bus) + 17'h0_0001;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("address did not step by one");
  c_write: cover property (@(posedge ref_clk) $fell(ctl_pins.program_strobe_n));
  c_verify: cover property (@(posedge ref_clk) $fell(ctl_pins.output_enable_n));
  c_done: cover property (@(posedge ref_clk) $rose(done) && !fail);
  c_fail: cover property (@(posedge ref_clk) $rose(fail));
endmodule // oppp_programmer

// *** dv/oppp_target_model.sv ***
// behavioural target device in prom mode, seen at the programmer's pins
// assumes the host's data enable is high while the host drives the data bus
`timescale 1ns/1ps
module oppp_target_model (
  input wire oppp_pkg::oppp_mode_t mode_pins,
  input wire oppp_pkg::oppp_ctl_t ctl_pins,
  input wire logic [16:0] addr,
  input wire logic [7:0] host_data,
  input wire logic host_oe,
  input wire logic [16:0] weak_addr,
  input wire logic [7:0] weak_need,
  output logic rom_enabled,
  output logic cpu_halted,
  output logic [7:0] data_wire,
  output logic [15:0] cpu_word
);
  logic [7:0] mem [0:131071];
  int pulses [0:131071];
  logic [7:0] last;
  logic prom_mode;
  logic rd_sel;
  logic wr_sel;
  assign rom_enabled = mode_pins.mode_select_high;
  assign prom_mode = (mode_pins === 5'b00011);
  assign cpu_halted = prom_mode;
  assign rd_sel = prom_mode && (ctl_pins === 3'b001);
  assign wr_sel = prom_mode && (ctl_pins === 3'b010);
  // 16-bit cpu view of a rom word; this model puts the even byte low
  assign cpu_word = !rom_enabled ? 16'hFFFF :
    {mem[{addr[16:1], 1'b1}], mem[{addr[16:1], 1'b0}]};
  initial begin
    for (int i = 0; i < 131072; i++) begin
      mem[i] = 8'hFF;
      pulses[i] = 0;
    end
    last = 8'hFF;
  end
  // weak cells ignore their first weak_need pulses; cells only clear bits
  // the strobe edge changes ce as well, so the pulse is caught on entry
  always @(posedge wr_sel) begin
    pulses[addr] += 1;
    if (!(addr == weak_addr && pulses[addr] <= weak_need))
      mem[addr] = mem[addr] & data_wire;
  end
  // no pull on the bus: undriven it shows the inverse of the last value
  always @* begin
    if (host_oe) begin
      data_wire = host_data;
      last = host_data;
    end else if (rd_sel) begin
      data_wire = mem[addr];
      last = mem[addr];
    end else
      data_wire = ~last;
  end
endmodule // oppp_target_model

// *** dv/testbench.sv ***
// self-checking bench: programmer against a behavioural prom target
// assumes the small part, a shortened pulse and mostly blank images
`timescale 1ns/1ps
module testbench;
  localparam logic [16:0] TOP = oppp_pkg::TOP_32K;
  logic ref_clk = 0, srst = 1, start = 0, byte_valid = 0;
  logic byte_ready, busy, done, fail, prom_data_oe, rom_en, halted;
  logic [15:0] cpu_word;
  logic [7:0] byte_data = 8'h00, prom_data_out, prom_data_in;
  logic [16:0] prom_address_bus, weak_addr = 17'h0_0002;
  logic [7:0] weak_need = 8'h02;
  oppp_pkg::oppp_mode_t mode_pins;
  oppp_pkg::oppp_ctl_t ctl_pins;
  logic [7:0] img [0:32767];
  int error_cnt = 0, total_checks = 0, cycles = 0;
  always #20 ref_clk = ~ref_clk;
  oppp_programmer #(.PW_CYCLES(20), .BIG_PART(1'b0)) oppp_programmer_inst (
    .ref_clk(ref_clk), .srst(srst), .start(start), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .busy(busy),
    .done(done), .fail(fail), .mode_pins(mode_pins), .ctl_pins(ctl_pins),
    .prom_address_bus(prom_address_bus), .prom_data_out(prom_data_out),
    .prom_data_oe(prom_data_oe), .prom_data_in(prom_data_in));
  oppp_target_model oppp_target_model_inst (
    .mode_pins(mode_pins), .ctl_pins(ctl_pins), .addr(prom_address_bus),
    .host_data(prom_data_out), .host_oe(prom_data_oe),
    .weak_addr(weak_addr), .weak_need(weak_need), .rom_enabled(rom_en),
    .cpu_halted(halted), .data_wire(prom_data_in), .cpu_word(cpu_word));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic int exp_pulses(input int a);
    if (a > TOP || img[a] == 8'hFF) return 0;
    return (a == weak_addr) ? weak_need + 1 : 1;
  endfunction
  // host drive during a verify window would fight the target
  always @(posedge ref_clk) begin
    cycles++;
    if (prom_data_oe === 1'b1 && ctl_pins.output_enable_n === 1'b0)
      check(1, 0);
    // a clean run needs about 68k cycles: two per blank address plus pulses
    if (cycles == 100000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic run();
    @(negedge ref_clk);
    start = 1;
    for (int a = 0; a <= TOP; a++) begin
      byte_valid = 1;
      byte_data = img[a];
      while (!byte_ready && !done) @(negedge ref_clk);
      if (done) break;
      if (a == 0) check(mode_pins, 5'b00011);
      if (a == 0) check({busy, halted, rom_en}, 3'b110);
      @(negedge ref_clk);
    end
    byte_valid = 0;
    while (!done) @(negedge ref_clk);
  endtask
  initial begin
    void'($urandom(32'h104f362d));
    for (int i = 0; i <= TOP; i++) img[i] = 8'hFF;
    for (int i = 0; i < 12; i++) img[i] = $urandom;
    img[2] = $urandom & 8'h7F;
    img[3] = 8'h00;
    img[TOP - 1] = 8'hFF;
    img[TOP] = $urandom & 8'hFE;
    repeat (2) @(negedge ref_clk);
    srst = 0;
    check({mode_pins, ctl_pins, prom_data_oe, busy}, 10'h39C);
    run();
    check({done, fail}, 2'b10);
    for (int i = 0; i < 131072; i++) begin
      check(oppp_target_model_inst.mem[i], i <= TOP ? img[i] : 8'hFF);
      check(oppp_target_model_inst.pulses[i], exp_pulses(i));
    end
    @(negedge ref_clk);
    start = 0;
    repeat (3) @(negedge ref_clk);
    check(done, 0);
    check({halted, rom_en}, 2'b01);
    check(cpu_word, {img[1], img[0]});
    // that cell already holds 00, so no pulse can make it read back 5a
    img[3] = 8'h5A;
    weak_addr = 17'h0_0003;
    weak_need = 8'hFF;
    run();
    check({done, fail}, 2'b11);
    check(oppp_target_model_inst.pulses[3], 1 + oppp_pkg::MAX_TRIES);
    conclude();
  end
endmodule // testbench
